/* File: common/tpp_pkg.sv */
package tpp_pkg;

   //----------------------------------------------------------------------
   // Timing
   //----------------------------------------------------------------------
   localparam int unsigned CLK_HZ            = 100_000_000;
   localparam int unsigned SIMPLEX_RATE_HZ   = 12800;
   localparam int unsigned TRIPLEX_RATE_HZ   = 4267;
   localparam int unsigned GAP_LIMIT_US      = 312;
   localparam int unsigned PREP_SLOT_MS      = 250;
   localparam int unsigned SIMPLEX_CYC       = CLK_HZ / SIMPLEX_RATE_HZ;
   localparam int unsigned TRIPLEX_CYC       = CLK_HZ / TRIPLEX_RATE_HZ;
   localparam int unsigned GAP_LIMIT_CYC     = GAP_LIMIT_US * (CLK_HZ / 1_000_000);
   localparam int unsigned PREP_SLOT_CYC     = PREP_SLOT_MS * (CLK_HZ / 1000);
   localparam int unsigned BANK_WORDS        = 1024;

   //----------------------------------------------------------------------
   // Register map (Wishbone, byte addresses)
   //----------------------------------------------------------------------
   localparam logic [3:0]  ADR_CTRL          = 4'h0;
   localparam logic [3:0]  ADR_STAT          = 4'h4;
   localparam logic [3:0]  ADR_WORD          = 4'h8;
   localparam logic [3:0]  ADR_COUNT         = 4'hC;
   localparam int unsigned CTRL_START        = 0;
   localparam int unsigned CTRL_TRIPLEX      = 1;
   localparam int unsigned CTRL_PREP         = 2;
   localparam logic [31:0] CTRL_RESET        = 32'h0000_0000;
   localparam int unsigned WORD_W            = 16;

   typedef enum logic [1:0] {
      TPP_MOT_STOP,
      TPP_MOT_FWD,
      TPP_MOT_REV
   } tpp_motion_e;

   typedef struct packed {
      logic [WORD_W-1:0] data;
      logic              id_word;
   } tpp_word_s;

endpackage : tpp_pkg

/* File: hw/tpp_fifo.sv */
`timescale 1ns/1ns
module tpp_fifo #(
   parameter int unsigned WIDTH = 17,
   parameter int unsigned DEPTH = 4
) (
   input  wire logic             mclk_i,
   input  wire logic             srst_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   output logic      [WIDTH-1:0] out_data_o,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   initial begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("tpp_fifo: DEPTH must be a power of two >= 2");
   end

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0]      wr_ptr_r;
   logic [AW:0]      rd_ptr_r;
   logic             push;
   logic             pop;

   //----------------------------------------------------------------------
   // Flags
   //----------------------------------------------------------------------
   // Full when pointers differ only in the wrap bit
   assign in_ready_o  = (wr_ptr_r[AW] == rd_ptr_r[AW]) || (wr_ptr_r[AW-1:0] != rd_ptr_r[AW-1:0]);
   assign out_valid_o = (wr_ptr_r != rd_ptr_r);
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;
   assign out_data_o  = mem_r[rd_ptr_r[AW-1:0]];

   // Storage
   always_ff @(posedge mclk_i) begin
      if (push) begin
         mem_r[wr_ptr_r[AW-1:0]] <= in_data_i;
      end
   end

   // Pointers
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
         if (pop)  rd_ptr_r <= rd_ptr_r + 1'b1;
      end
   end
endmodule : tpp_fifo

/* File: hw/tpp_pacer.sv */
// Register access over Wishbone and the placing of the registers were decided locally.
`timescale 1ns/1ns
module tpp_pacer #(
   parameter int unsigned PREP_SLOT_CYCLES = tpp_pkg::PREP_SLOT_CYC,
   parameter int unsigned BANK_LEN         = tpp_pkg::BANK_WORDS
) (
   input  wire logic                        mclk_i,
   input  wire logic                        srst_i,
   // Wishbone slave
   input  wire logic                        wb_cyc_i,
   input  wire logic                        wb_stb_i,
   input  wire logic                        wb_we_i,
   input  wire logic [3:0]                  wb_adr_i,
   input  wire logic [3:0]                  wb_sel_i,
   input  wire logic [31:0]                 wb_dat_i,
   output logic      [31:0]                 wb_dat_o,
   output logic                             wb_ack_o,
   // Host cycle-steal handshake
   output logic                             load_channel_request_o,
   input  wire logic                        channel_request_ack_i,
   input  wire logic [tpp_pkg::WORD_W-1:0]  mem_word_i,
   // Panel and tape transport
   input  wire logic                        preparation_switch_i,
   input  wire logic                        tape_start_marker_i,
   input  wire logic                        clear_tape_window_i,
   input  wire logic                        tape_at_speed_i,
   input  wire logic                        id_found_i,
   output logic                             go_forward_cmd_o,
   output logic                             go_reverse_cmd_o,
   output logic                             transfer_in_progress_o,
   output logic                             end_of_bank_flag_o,
   // Word stream to tape writer
   output logic [tpp_pkg::WORD_W-1:0]       tape_word_o,
   output logic                             tape_word_id_o,
   output logic                             tape_word_valid_o,
   input  wire logic                        tape_word_ready_i,
   output logic                             gap_detect_o
);
   initial begin
      if (PREP_SLOT_CYCLES < 2) $error("tpp_pacer: PREP_SLOT_CYCLES too small");
      if (BANK_LEN < 1 || BANK_LEN > 65535) $error("tpp_pacer: BANK_LEN out of range");
   end

   typedef enum logic [1:0] {
      TPP_IDLE,
      TPP_SEEK,
      TPP_RUN
   } tpp_state_e;

   tpp_state_e                      state_r;
   logic [31:0]                     tape_control_word_r;
   logic [tpp_pkg::WORD_W-1:0]      tape_write_word_register_r;
   logic                            word_loaded_r;
   logic                            load_channel_flag_r;
   logic [31:0]                     pace_cnt_r;
   logic [31:0]                     slot_cnt_r;
   logic                            slot_open_r;
   logic [31:0]                     gap_cnt_r;
   logic                            gap_r;
   logic                            next_is_id_r;
   logic [15:0]                     xfer_cnt_r;
   logic                            eob_r;
   logic                            tip_r;
   tpp_pkg::tpp_motion_e            motion_r;
   logic                            ack_clears;
   logic                            fifo_in_ready;
   logic                            fifo_push;
   tpp_pkg::tpp_word_s              fifo_in;
   tpp_pkg::tpp_word_s              fifo_out;
   logic                            wb_hit;
   logic                            start_w;
   logic                            running;
   logic                            prep;
   logic                            triplex;
   logic [31:0]                     pace_len;

   // Width-safe 32-bit constant
   function automatic logic [31:0] c32(input int unsigned v);
      c32 = v[31:0];
   endfunction : c32

   //----------------------------------------------------------------------
   // Register bus
   //----------------------------------------------------------------------
   assign wb_hit  = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign start_w = wb_hit && wb_we_i && (wb_adr_i == tpp_pkg::ADR_CTRL) && wb_sel_i[0]
                    && wb_dat_i[tpp_pkg::CTRL_START];
   assign running = tape_control_word_r[tpp_pkg::CTRL_START];
   assign prep    = tape_control_word_r[tpp_pkg::CTRL_PREP] && preparation_switch_i;
   assign triplex = tape_control_word_r[tpp_pkg::CTRL_TRIPLEX];

   // One-cycle ack after each access; unmapped reads return zero
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_hit;
         if (wb_hit && !wb_we_i) begin
            unique case (wb_adr_i)
               tpp_pkg::ADR_CTRL:  wb_dat_o <= tape_control_word_r;
               tpp_pkg::ADR_STAT:  wb_dat_o <= {26'h0, gap_r, next_is_id_r, tip_r, eob_r,
                                                load_channel_flag_r, word_loaded_r};
               tpp_pkg::ADR_WORD:  wb_dat_o <= {16'h0, tape_write_word_register_r};
               tpp_pkg::ADR_COUNT: wb_dat_o <= {16'h0, xfer_cnt_r};
               default:            wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Tape control word; end of bank clears it and stops motion
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         tape_control_word_r <= tpp_pkg::CTRL_RESET;
      end else if (eob_r || (prep == 1'b0 && tape_control_word_r[tpp_pkg::CTRL_PREP]
                             && state_r == TPP_RUN)) begin
         tape_control_word_r <= 32'h0000_0000;
      end else if (wb_hit && wb_we_i && wb_adr_i == tpp_pkg::ADR_CTRL && wb_sel_i[0]) begin
         tape_control_word_r <= {29'h0, wb_dat_i[2:0]};
      end
   end

   //----------------------------------------------------------------------
   // Tape motion sequence
   //----------------------------------------------------------------------
   // Start at tape start goes forward at once; inside the window we seek back first
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         state_r  <= TPP_IDLE;
         motion_r <= tpp_pkg::TPP_MOT_STOP;
         tip_r    <= 1'b0;
      end else if (!running) begin
         state_r  <= TPP_IDLE;
         motion_r <= tpp_pkg::TPP_MOT_STOP;
         tip_r    <= 1'b0;
      end else begin
         unique case (state_r)
            TPP_IDLE: begin
               if (tape_start_marker_i) begin
                  motion_r <= tpp_pkg::TPP_MOT_FWD;
                  state_r  <= TPP_RUN;
               end else if (clear_tape_window_i) begin
                  motion_r <= tpp_pkg::TPP_MOT_REV;
                  state_r  <= TPP_SEEK;
               end else begin
                  motion_r <= tpp_pkg::TPP_MOT_FWD;
                  state_r  <= TPP_RUN;
               end
            end
            TPP_SEEK: begin
               if (id_found_i || tape_start_marker_i) begin
                  motion_r <= tpp_pkg::TPP_MOT_FWD;
                  state_r  <= TPP_RUN;
               end
            end
            TPP_RUN: begin
               // Preparation ignores the ID match; speed alone starts transfer
               if (tape_at_speed_i && (prep || id_found_i)) tip_r <= 1'b1;
            end
         endcase
      end
   end

   assign go_forward_cmd_o       = (motion_r == tpp_pkg::TPP_MOT_FWD);
   assign go_reverse_cmd_o       = (motion_r == tpp_pkg::TPP_MOT_REV);
   assign transfer_in_progress_o = tip_r;
   assign end_of_bank_flag_o     = eob_r;

   //----------------------------------------------------------------------
   // Request pacing and the load channel flag
   //----------------------------------------------------------------------
   assign pace_len = triplex ? c32(tpp_pkg::TRIPLEX_CYC) : c32(tpp_pkg::SIMPLEX_CYC);

   // Period counter: raises a request at each simplex or triplex interval tick that finds the flag low
   always_ff @(posedge mclk_i) begin
      if (srst_i || !tip_r) begin
         pace_cnt_r <= 32'h0000_0000;
      end else if (pace_cnt_r >= pace_len - 32'h0000_0001) begin
         pace_cnt_r <= 32'h0000_0000;
      end else begin
         pace_cnt_r <= pace_cnt_r + 32'h0000_0001;
      end
   end

   // Quarter-second slot; restarts when an ack is let through
   always_ff @(posedge mclk_i) begin
      if (srst_i || !prep) begin
         slot_cnt_r  <= 32'h0000_0000;
         slot_open_r <= 1'b0;
      end else if (ack_clears) begin
         slot_cnt_r  <= 32'h0000_0000;
         slot_open_r <= 1'b0;
      end else if (slot_cnt_r >= c32(PREP_SLOT_CYCLES) - 32'h0000_0001) begin
         slot_open_r <= 1'b1;
      end else begin
         slot_cnt_r  <= slot_cnt_r + 32'h0000_0001;
      end
   end

   // Acks clear only when not preparing, or when the slot is open, and FIFO has room
   assign ack_clears = channel_request_ack_i && load_channel_flag_r && fifo_in_ready
                       && (!prep || slot_open_r);

   // Request flag: idle or end of bank clear wins over set; an ack clear wins over a period tick, as set needs a low flag
   always_ff @(posedge mclk_i) begin
      if (srst_i || !tip_r || eob_r) begin
         load_channel_flag_r <= 1'b0;
      end else if (pace_cnt_r == 32'h0000_0000 && !load_channel_flag_r) begin
         load_channel_flag_r <= 1'b1;
      end else if (ack_clears) begin
         load_channel_flag_r <= 1'b0;
      end
   end
   assign load_channel_request_o = load_channel_flag_r;

   //----------------------------------------------------------------------
   // Stolen word capture and bank count
   //----------------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         tape_write_word_register_r <= '0;
         word_loaded_r              <= 1'b0;
         xfer_cnt_r                 <= 16'h0000;
         eob_r                      <= 1'b0;
      end else begin
         word_loaded_r <= ack_clears;
         eob_r         <= 1'b0;
         if (start_w) begin
            xfer_cnt_r <= 16'h0000;
         end
         if (ack_clears) begin
            tape_write_word_register_r <= mem_word_i;
            if (xfer_cnt_r == BANK_LEN[15:0] - 16'h0001) begin
               eob_r      <= 1'b1;
               xfer_cnt_r <= 16'h0000;
            end else begin
               xfer_cnt_r <= xfer_cnt_r + 16'h0001;
            end
         end
      end
   end

   //----------------------------------------------------------------------
   // Gap sensing on outgoing words
   //----------------------------------------------------------------------
   // Spacing is measured between words pushed into the word FIFO
   always_ff @(posedge mclk_i) begin
      if (srst_i || !tip_r) begin
         gap_cnt_r    <= 32'h0000_0000;
         gap_r        <= 1'b0;
         next_is_id_r <= 1'b1;
      end else if (fifo_push) begin
         gap_cnt_r    <= 32'h0000_0000;
         gap_r        <= 1'b0;
         next_is_id_r <= 1'b0;
      end else if (gap_cnt_r > c32(tpp_pkg::GAP_LIMIT_CYC)) begin
         gap_r        <= 1'b1;
         next_is_id_r <= 1'b1;
      end else begin
         gap_cnt_r    <= gap_cnt_r + 32'h0000_0001;
      end
   end
   assign gap_detect_o = gap_r;

   //----------------------------------------------------------------------
   // Word FIFO toward the tape writer
   //----------------------------------------------------------------------
   // Writer only sees a word once it sits in the word register
   assign fifo_push    = word_loaded_r;
   assign fifo_in.data = tape_write_word_register_r;
   assign fifo_in.id_word = next_is_id_r;

   tpp_fifo #(
      .WIDTH ($bits(tpp_pkg::tpp_word_s)),
      .DEPTH (4)
   ) u_fifo (
      .mclk_i      (mclk_i),
      .srst_i      (srst_i),
      .in_data_i   (fifo_in),
      .in_valid_i  (fifo_push),
      .in_ready_o  (fifo_in_ready),
      .out_data_o  (fifo_out),
      .out_valid_o (tape_word_valid_o),
      .out_ready_i (tape_word_ready_i)
   );

   assign tape_word_o    = fifo_out.data;
   assign tape_word_id_o = fifo_out.id_word;
endmodule : tpp_pacer

/* File: tb/tpp_host_model.sv */
`timescale 1ns/1ns
module tpp_host_model #(
   parameter int unsigned ACK_DLY = 3
) (
   input  wire logic        mclk_i,
   input  wire logic        srst_i,
   input  wire logic        request_i,
   output logic             ack_o,
   output logic [15:0]      word_o
);
   logic [7:0]  wait_r;
   logic [15:0] seq_r;
   logic        acked_r;
   // Host keeps acking at instruction ends while the request stands
   always_ff @(posedge mclk_i) begin
      if (srst_i || ack_o || !request_i) begin
         wait_r <= 8'h00;
         ack_o  <= 1'b0;
      end else if (wait_r == 8'(ACK_DLY)) begin
         ack_o <= 1'b1;
      end else begin
         wait_r <= wait_r + 8'h01;
      end
   end
   // Next core word only once our ack really cleared the request; a refused ack leaves it standing
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         seq_r   <= 16'h5A00;
         acked_r <= 1'b0;
      end else begin
         acked_r <= ack_o && request_i;
         if (acked_r && !request_i) begin
            seq_r <= seq_r + 16'h0001;
         end
      end
   end
   // Released bus shows the inverse so a stale word cannot pass
   assign word_o = ack_o ? seq_r : ~seq_r;
endmodule : tpp_host_model

/* File: tb/tpp_pacer_monitor.sv */
`timescale 1ns/1ns
module tpp_pacer_monitor (
   input  wire logic mclk_i,
   input  wire logic srst_i,
   input  wire logic wb_cyc_i,
   input  wire logic wb_stb_i,
   input  wire logic wb_ack_o,
   input  wire logic load_channel_request_o,
   input  wire logic channel_request_ack_i,
   input  wire logic tape_start_marker_i,
   input  wire logic tape_at_speed_i,
   input  wire logic go_forward_cmd_o,
   input  wire logic go_reverse_cmd_o,
   input  wire logic transfer_in_progress_o,
   input  wire logic end_of_bank_flag_o,
   input  wire logic tape_word_valid_o,
   input  wire logic tape_word_ready_i,
   input  wire logic gap_detect_o
);
   // Handshake lags the push by a cycle or two, hence the slack
   localparam int GAP_MIN = tpp_pkg::GAP_LIMIT_CYC - 4;
   logic [15:0] idle_r;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (srst_i);
   // Cycles since the tape side last took a word
   always_ff @(posedge mclk_i) begin
      if (srst_i || (tape_word_valid_o && tape_word_ready_i)) begin
         idle_r <= 16'h0000;
      end else if (idle_r != 16'hFFFF) begin
         idle_r <= idle_r + 16'h0001;
      end
   end
   a_bus_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
   a_bus_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
   a_req_clear_ack: assert property ($fell(load_channel_request_o) |-> $past(channel_request_ack_i))
      else $error("request dropped without ack");
   a_word_after_clear: assert property ($fell(load_channel_request_o) && tape_word_ready_i
      |-> ##[1:4] tape_word_valid_o) else $error("no word after stolen cycle");
   a_gap_needs_idle: assert property ($rose(gap_detect_o) |-> idle_r >= GAP_MIN) else $error("early gap");
   a_eob_one_cycle: assert property (end_of_bank_flag_o |=> !end_of_bank_flag_o) else $error("eob held");
   a_eob_motion_stop: assert property (end_of_bank_flag_o |-> ##[0:2] !(go_forward_cmd_o || go_reverse_cmd_o))
      else $error("tape still moving");
   a_motion_exclusive: assert property (!(go_forward_cmd_o && go_reverse_cmd_o)) else $error("both dirs");
   a_no_rev_at_start: assert property ($rose(go_reverse_cmd_o) |-> !$past(tape_start_marker_i))
      else $error("reverse at tape start");
   a_tip_at_speed: assert property ($rose(transfer_in_progress_o) |-> $past(tape_at_speed_i))
      else $error("transfer before speed");
   c_eob: cover property (end_of_bank_flag_o);
   c_gap: cover property ($rose(gap_detect_o));
   c_reverse: cover property ($rose(go_reverse_cmd_o));
endmodule : tpp_pacer_monitor

bind tpp_pacer tpp_pacer_monitor tpp_pacer_monitor_inst (
   .mclk_i(mclk_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .load_channel_request_o(load_channel_request_o), .channel_request_ack_i(channel_request_ack_i),
   .tape_start_marker_i(tape_start_marker_i), .tape_at_speed_i(tape_at_speed_i),
   .go_forward_cmd_o(go_forward_cmd_o), .go_reverse_cmd_o(go_reverse_cmd_o),
   .transfer_in_progress_o(transfer_in_progress_o), .end_of_bank_flag_o(end_of_bank_flag_o),
   .tape_word_valid_o(tape_word_valid_o), .tape_word_ready_i(tape_word_ready_i), .gap_detect_o(gap_detect_o)
);

/* File: tb/tpp_pacer_tb.sv */
`timescale 1ns/1ns
module tpp_pacer_tb;
   localparam int SLOT = 9000;
   localparam int GAP  = tpp_pkg::GAP_LIMIT_CYC;
   logic        mclk_i, srst_i, cyc, stb, we, ack, req, hack, psw, mark, win, idf, fwd, rev, tip, eob;
   logic        wval, wrdy, wid, gap, req_d, gap_d, spd;
   logic [3:0]  adr;
   logic [31:0] wdat, rdat, rq;
   logic [15:0] hword, tword;
   int          fail_count, total_checks, cyc_n, eob_n, gap_n, ack_n, last_push, d;
   int          rise_q[$], clr_q[$];
   logic [16:0] word_q[$];

   tpp_pacer #(.PREP_SLOT_CYCLES(SLOT), .BANK_LEN(5)) tpp_pacer_inst (
      .mclk_i(mclk_i), .srst_i(srst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .load_channel_request_o(req),
      .channel_request_ack_i(hack), .mem_word_i(hword), .preparation_switch_i(psw), .tape_start_marker_i(mark),
      .clear_tape_window_i(win), .tape_at_speed_i(spd), .id_found_i(idf), .go_forward_cmd_o(fwd),
      .go_reverse_cmd_o(rev), .transfer_in_progress_o(tip), .end_of_bank_flag_o(eob), .tape_word_o(tword),
      .tape_word_id_o(wid), .tape_word_valid_o(wval), .tape_word_ready_i(wrdy), .gap_detect_o(gap));
   tpp_host_model tpp_host_model_inst (
      .mclk_i(mclk_i), .srst_i(srst_i), .request_i(req), .ack_o(hack), .word_o(hword));

   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end

   // Event log: request edges, acks, words taken, end of bank, gaps
   always @(posedge mclk_i) begin
      cyc_n <= cyc_n + 1;
      req_d <= req;
      gap_d <= gap;
      if (req && !req_d) rise_q.push_back(cyc_n);
      if (!req && req_d) clr_q.push_back(cyc_n);
      if (hack && req) ack_n <= ack_n + 1;
      if (eob) eob_n <= eob_n + 1;
      if (gap && !gap_d) gap_n <= gap_n + 1;
      if (wval && wrdy) begin
         word_q.push_back({wid, tword});
         last_push <= cyc_n;
      end
   end

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask : check

   function automatic bit met(input int sel, input int n);
      case (sel)
         0: return rise_q.size() >= n;
         1: return word_q.size() >= n;
         default: return gap === 1'b1;
      endcase
   endfunction : met

   // Bounded wait; running out ends the run as a mismatch
   task automatic wait_for(input int sel, input int n, input int lim);
      int k;
      k = 0;
      while (!met(sel, n)) begin
         if (k == lim) begin
            fail_count++;
            $display("[ERR] t=%0t wait %0h got=%0h exp=%0h", $time, sel, word_q.size(), n);
            print_verdict();
         end
         @(posedge mclk_i);
         k++;
      end
   endtask : wait_for

   // Classic cycle: hold until ack is sampled, then drop for a cycle
   task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] v);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= v;
      d = 0;
      do begin
         @(posedge mclk_i);
         d++;
         if (d > 40) begin
            fail_count++;
            print_verdict();
         end
      end while (ack !== 1'b1);
      rq = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge mclk_i);
   endtask : xfer

   initial begin
      {srst_i, cyc, stb, we, psw, mark, win, idf, wrdy, spd, adr, wdat} = {1'b1, 8'h00, 1'b1, 36'h0};
      {fail_count, total_checks, cyc_n, eob_n, gap_n, ack_n, last_push} = '0;
      repeat (20) @(posedge mclk_i);
      srst_i <= 1'b0;
      xfer(1'b1, 4'h2, 32'hFFFF_FFFF);
      xfer(1'b0, 4'h2, 32'h0);
      check(rq, 32'h0);
      // Simplex start inside the clear window, tape side stalled until the FIFO fills and a gap shows
      win <= 1'b1;
      xfer(1'b1, tpp_pkg::ADR_CTRL, 32'h1);
      repeat (3) @(posedge mclk_i);
      check({rev, fwd}, 32'h2);
      idf <= 1'b1;
      repeat (3) @(posedge mclk_i);
      check({rev, fwd, tip}, 32'h3);
      wait_for(0, 5, 50000);
      wait_for(2, 0, 32000);
      check(cyc_n - clr_q[3] >= GAP && cyc_n - clr_q[3] < GAP + 12, 32'h1);
      check(req, 32'h1);
      for (int i = 0; i < 4; i++) check(rise_q[i+1] - rise_q[i], tpp_pkg::SIMPLEX_CYC);
      wrdy <= 1'b1;
      wait_for(1, 5, 9000);
      repeat (10) @(posedge mclk_i);
      for (int k = 0; k < 5; k++) check(word_q[k], {k == 0 || k == 4, 16'h5A00 + 16'(k)});
      check({eob_n == 1, gap_n == 1, fwd, rev}, 32'hC);
      xfer(1'b0, tpp_pkg::ADR_CTRL, 32'h0);
      check(rq, 32'h0);
      // Preparation run from tape start, no ID needed, transfer waits for speed
      {mark, win, idf, psw, spd} <= 5'h12;
      xfer(1'b1, tpp_pkg::ADR_CTRL, 32'h5);
      repeat (3) @(posedge mclk_i);
      check({rev, fwd, tip}, 32'h2);
      spd <= 1'b1;
      repeat (3) @(posedge mclk_i);
      check(tip, 32'h1);
      wait_for(1, 8, 40000);
      for (int k = 5; k < 7; k++) check(clr_q[k+1] - clr_q[k] >= SLOT && clr_q[k+1] - clr_q[k] < SLOT + 20, 32'h1);
      check(ack_n > clr_q.size() + 4, 32'h1);
      check(word_q[5], 32'h15A05);
      check(word_q[7], 32'h05A07);
      print_verdict();
   end
endmodule : tpp_pacer_tb
